// ### common/sdp_pkg.sv
// Shared constants, types and command encodings of the SDRAM pin command interface
package sdp_pkg;

   // ****************************************************************
   // Widths and field positions
   // ****************************************************************
   localparam int ADDR_W      = 12;
   localparam int COL_W       = 8;
   localparam int AP_BIT      = 10;
   localparam int BANK_W      = 2;
   localparam int NUM_BANKS   = 4;
   localparam int DATA_W      = 16;
   localparam int BYTE_W      = 8;
   localparam int LANES       = 2;

   // ****************************************************************
   // Reset values and timing
   // ****************************************************************
   localparam logic [ADDR_W-1:0]    MODE_RST     = 12'h000;
   localparam logic [ADDR_W-1:0]    ROW_RST      = 12'h000;
   localparam logic [NUM_BANKS-1:0] BANKS_CLOSED = 4'h0;
   localparam int                   READ_LAT     = 2;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [3:0] {
      CMD_INHIBIT = 4'h0,
      CMD_NOP     = 4'h1,
      CMD_ACT     = 4'h2,
      CMD_READ    = 4'h3,
      CMD_WRITE   = 4'h4,
      CMD_PRE     = 4'h5,
      CMD_REF     = 4'h6,
      CMD_LMR     = 4'h7,
      CMD_BST     = 4'h8
   } sdp_cmd_t;

   typedef enum logic [1:0] {
      PWR_RUN     = 2'h0,
      PWR_DOWN    = 2'h1,
      PWR_SUSPEND = 2'h3,
      PWR_SELF    = 2'h2
   } sdp_pwr_t;

   typedef struct packed {
      logic              cs_n;
      logic              ras_n;
      logic              cas_n;
      logic              we_n;
      logic              bank_select_high;
      logic              bank_select_low;
      logic [ADDR_W-1:0] row_address_bus;
      logic              upper_byte_mask;
      logic              lower_byte_mask;
   } sdp_pins_t;

   typedef struct packed {
      logic              rd;
      logic              wr;
      logic [BANK_W-1:0] bank;
      logic [ADDR_W-1:0] row;
      logic [COL_W-1:0]  col;
      logic [LANES-1:0]  byte_en;
      logic [DATA_W-1:0] wdata;
   } sdp_core_req_t;

endpackage : sdp_pkg

// ### rtl/sdp_cmd_decode.sv
// Command decoder from the strobe pins
`timescale 1ns/1ps
module sdp_cmd_decode
   import sdp_pkg::*;
(
   input  sdp_pkg::sdp_pins_t pins,
   output sdp_pkg::sdp_cmd_t  cmd
);
   import sdp_pkg::*;

   always_comb begin
      if (pins.cs_n) begin
         cmd = CMD_INHIBIT;
      end else begin
         case ({pins.ras_n, pins.cas_n, pins.we_n})
            3'h3:    cmd = CMD_ACT;
            3'h5:    cmd = CMD_READ;
            3'h4:    cmd = CMD_WRITE;
            3'h2:    cmd = CMD_PRE;
            3'h1:    cmd = CMD_REF;
            3'h0:    cmd = CMD_LMR;
            3'h6:    cmd = CMD_BST;
            default: cmd = CMD_NOP;
         endcase
      end
   end

endmodule : sdp_cmd_decode

// ### rtl/sdp_device.sv
// Device side of the SDRAM pin command and data interface
`timescale 1ns/1ps
module sdp_device
   import sdp_pkg::*;
(
   input  wire logic                             sys_clk,
   input  wire logic                             nrst,
   input  wire logic                             cke,
   input  sdp_pkg::sdp_pins_t                    pins,
   input  wire logic [sdp_pkg::DATA_W-1:0]       data_bus_level,
   output logic      [sdp_pkg::DATA_W-1:0]       data_bus_drive,
   output logic      [sdp_pkg::DATA_W-1:0]       data_bus_en,
   output sdp_pkg::sdp_core_req_t                core_req,
   input  wire logic [sdp_pkg::DATA_W-1:0]       core_rdata,
   output logic      [sdp_pkg::ADDR_W-1:0]       mode_reg,
   output logic      [sdp_pkg::NUM_BANKS-1:0]    bank_open,
   output sdp_pkg::sdp_pwr_t                     power_state
);
   import sdp_pkg::*;

   sdp_cmd_t                  cmd;
   logic                      edge_ok_q;
   logic                      edge_ok;
   logic [BANK_W-1:0]         bank;
   logic [ADDR_W-1:0]         addr;
   logic [LANES-1:0]          mask;
   logic                      auto_pre;
   logic [NUM_BANKS-1:0]      bank_open_q;
   logic [ADDR_W-1:0]         open_row_q [NUM_BANKS];
   logic [ADDR_W-1:0]         mode_q;
   sdp_core_req_t             core_q;
   logic [READ_LAT-1:0]       rd_pipe_q;
   logic [LANES-1:0]          mask1_q;
   logic [LANES-1:0]          mask2_q;
   logic [DATA_W-1:0]         dout_q;
   logic [LANES-1:0]          lane_oe_q;
   sdp_pwr_t                  pwr_q;

   function automatic logic [DATA_W-1:0] lanes_to_bits(input logic [LANES-1:0] l);
      lanes_to_bits = {{BYTE_W{l[1]}}, {BYTE_W{l[0]}}};
   endfunction : lanes_to_bits

   sdp_cmd_decode u_dec (
      .pins (pins),
      .cmd  (cmd)
   );

   // ****************************************************************
   // Clock enable qualification
   // ****************************************************************
   // Enable level is taken apart from the other inputs and qualifies the next edge
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         edge_ok_q <= 1'b0;
      end else begin
         edge_ok_q <= cke;
      end
   end

   assign edge_ok  = edge_ok_q;
   assign bank     = {pins.bank_select_high, pins.bank_select_low};
   assign addr     = pins.row_address_bus;
   assign mask     = {pins.upper_byte_mask, pins.lower_byte_mask};
   assign auto_pre = addr[AP_BIT];

   // ****************************************************************
   // Bank and row tracking
   // ****************************************************************
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         bank_open_q <= BANKS_CLOSED;
         for (int i = 0; i < NUM_BANKS; i++) begin
            open_row_q[i] <= ROW_RST;
         end
      end else if (edge_ok) begin
         case (cmd)
            CMD_ACT: begin
               bank_open_q[bank] <= 1'b1;
               open_row_q[bank]  <= addr;
            end
            CMD_READ, CMD_WRITE: begin
               if (auto_pre) begin
                  bank_open_q[bank] <= 1'b0;
               end
            end
            CMD_PRE: begin
               if (addr[AP_BIT]) begin
                  bank_open_q <= BANKS_CLOSED;
               end else begin
                  bank_open_q[bank] <= 1'b0;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ****************************************************************
   // Mode register
   // ****************************************************************
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         mode_q <= MODE_RST;
      end else if (edge_ok && cmd == CMD_LMR) begin
         mode_q <= addr;
      end
   end

   // ****************************************************************
   // Core access requests
   // ****************************************************************
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         core_q <= '0;
      end else if (edge_ok) begin
         core_q.rd <= (cmd == CMD_READ);
         core_q.wr <= (cmd == CMD_WRITE) && (mask != 2'h3);
         if (cmd == CMD_READ || cmd == CMD_WRITE) begin
            core_q.bank    <= bank;
            core_q.row     <= open_row_q[bank];
            core_q.col     <= addr[COL_W-1:0];
            core_q.byte_en <= ~mask;
            core_q.wdata   <= data_bus_level;
         end
      end else begin
         core_q.rd <= 1'b0;
         core_q.wr <= 1'b0;
      end
   end

   // ****************************************************************
   // Read data path and output drivers
   // ****************************************************************
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rd_pipe_q <= '0;
         mask1_q   <= '0;
         mask2_q   <= '0;
         dout_q    <= '0;
         lane_oe_q <= '0;
      end else if (edge_ok) begin
         rd_pipe_q <= {rd_pipe_q[0], cmd == CMD_READ};
         mask1_q   <= mask;
         mask2_q   <= mask1_q;
         dout_q    <= core_rdata;
         lane_oe_q <= {LANES{rd_pipe_q[READ_LAT-1]}} & ~mask2_q;
      end
   end

   // ****************************************************************
   // Power states
   // ****************************************************************
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pwr_q <= PWR_RUN;
      end else if (cke) begin
         pwr_q <= PWR_RUN;
      end else begin
         case (pwr_q)
            PWR_RUN: begin
               if (edge_ok && cmd == CMD_REF && bank_open_q == BANKS_CLOSED) begin
                  pwr_q <= PWR_SELF;
               end else if (rd_pipe_q != '0 || core_q.wr) begin
                  pwr_q <= PWR_SUSPEND;
               end else begin
                  pwr_q <= PWR_DOWN;
               end
            end
            default: pwr_q <= pwr_q;
         endcase
      end
   end

   assign data_bus_drive = dout_q;
   assign data_bus_en    = lanes_to_bits(lane_oe_q);
   assign core_req    = core_q;
   assign mode_reg    = mode_q;
   assign bank_open   = bank_open_q;
   assign power_state = pwr_q;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   property p_row_capture;
      edge_ok && cmd == CMD_ACT |=> bank_open_q[$past(bank)] && open_row_q[$past(bank)] == $past(addr);
   endproperty
   a_row_capture: assert property (p_row_capture) else $error("row not captured");

   property p_col_capture;
      edge_ok && cmd == CMD_READ |=> core_q.rd && core_q.col == $past(addr[COL_W-1:0]) && core_q.bank == $past(bank);
   endproperty
   a_col_capture: assert property (p_col_capture) else $error("column not captured");

   property p_pre_all;
      edge_ok && cmd == CMD_PRE && addr[AP_BIT] |=> bank_open_q == BANKS_CLOSED;
   endproperty
   a_pre_all: assert property (p_pre_all) else $error("precharge all missed");

   property p_mode_load;
      edge_ok && cmd == CMD_LMR |=> mode_q == $past(addr);
   endproperty
   a_mode_load: assert property (p_mode_load) else $error("mode not loaded");

   property p_edge_ignored;
      !edge_ok |=> !core_q.rd && !core_q.wr && $stable(mode_q) && $stable(bank_open_q);
   endproperty
   a_edge_ignored: assert property (p_edge_ignored) else $error("invalid edge acted");

   property p_low_cke_state;
      !cke |=> pwr_q != PWR_RUN;
   endproperty
   a_low_cke_state: assert property (p_low_cke_state) else $error("no low power state");

   property p_deselect;
      pins.cs_n |=> !core_q.rd && !core_q.wr && $stable(mode_q) && $stable(bank_open_q);
   endproperty
   a_deselect: assert property (p_deselect) else $error("deselected command acted");

   property p_write_mask;
      edge_ok && cmd == CMD_WRITE && mask != 2'h3 |=> core_q.wr && core_q.byte_en == ~$past(mask)
         && core_q.wdata == $past(data_bus_level);
   endproperty
   a_write_mask: assert property (p_write_mask) else $error("write mask wrong");

   property p_read_mask_lat;
      edge_ok && cmd == CMD_READ ##1 edge_ok ##1 edge_ok
         |=> data_bus_en == lanes_to_bits(~$past(mask, 3));
   endproperty
   a_read_mask_lat: assert property (p_read_mask_lat) else $error("read mask latency wrong");

endmodule : sdp_device

// ### bench/sdp_ctrl_model.sv
// Behavioural memory controller driving the command pins and sharing the data wires
`timescale 1ns/1ps
module sdp_ctrl_model
   import sdp_pkg::*;
(
   input  wire logic [sdp_pkg::DATA_W-1:0] dev_dq,
   input  wire logic [sdp_pkg::DATA_W-1:0] dev_oe,
   input  wire logic                       sys_clk,
   output sdp_pkg::sdp_pins_t              pins,
   output logic      [sdp_pkg::DATA_W-1:0] data_bus_level
);
   import sdp_pkg::*;

   logic [DATA_W-1:0] host_dq = 16'h0000;
   logic              host_en = 1'b0;
   logic [DATA_W-1:0] last_q  = 16'h0000;

   initial pins = {1'b1, 3'h7, 2'h0, 12'h000, 2'h0};

   // ******************************
   // Shared data wires
   // ******************************
   // Released lines show the inverse of their last level
   always_comb begin
      for (int i = 0; i < DATA_W; i++) begin
         data_bus_level[i] = dev_oe[i] ? dev_dq[i] : (host_en ? host_dq[i] : ~last_q[i]);
      end
   end

   always_ff @(posedge sys_clk) begin
      last_q <= data_bus_level;
   end

   // One command for one edge, then back to inhibit
   task automatic cmd(input logic cs_n, input logic [2:0] rcw, input logic [1:0] bank,
                      input logic [ADDR_W-1:0] addr, input logic [1:0] mask,
                      input logic [DATA_W-1:0] wdata);
      @(posedge sys_clk);
      pins    <= {cs_n, rcw, bank, addr, mask};
      host_en <= (rcw == 3'b100);
      host_dq <= wdata;
      @(posedge sys_clk);
      pins    <= {1'b1, 3'h7, 2'h0, 12'h000, 2'h0};
      host_en <= 1'b0;
   endtask : cmd
endmodule : sdp_ctrl_model

// ### bench/sdram_pin_command_interface_bench.sv
// Self-checking bench of the device side of the pin command interface
`timescale 1ns/1ps
module sdram_pin_command_interface_bench;
   import sdp_pkg::*;

   localparam logic [2:0] ACT = 3'b011;
   localparam logic [2:0] RD  = 3'b101;
   localparam logic [2:0] WR  = 3'b100;
   localparam logic [2:0] PRE = 3'b010;
   localparam logic [2:0] LMR = 3'b000;
   localparam logic [2:0] REF = 3'b001;

   logic                 sys_clk    = 1'b0;
   logic                 nrst       = 1'b0;
   logic                 cke        = 1'b1;
   logic [DATA_W-1:0]    core_rdata = 16'h0000;
   sdp_pins_t            pins;
   logic [DATA_W-1:0]    data_bus_level;
   logic [DATA_W-1:0]    data_bus_drive;
   logic [DATA_W-1:0]    data_bus_en;
   sdp_core_req_t        core_req;
   logic [ADDR_W-1:0]    mode_reg;
   logic [NUM_BANKS-1:0] bank_open;
   sdp_pwr_t             power_state;
   int                   failures   = 0;
   int                   tests_run  = 0;

   always #10 sys_clk = ~sys_clk;

   sdp_device u_dut (.sys_clk(sys_clk), .nrst(nrst), .cke(cke), .pins(pins),
      .data_bus_level(data_bus_level), .data_bus_drive(data_bus_drive),
      .data_bus_en(data_bus_en),
      .core_req(core_req), .core_rdata(core_rdata), .mode_reg(mode_reg),
      .bank_open(bank_open), .power_state(power_state));

   sdp_ctrl_model u_ctrl (.dev_dq(data_bus_drive), .dev_oe(data_bus_en), .sys_clk(sys_clk),
      .pins(pins), .data_bus_level(data_bus_level));

   // ******************************
   // Helpers
   // ******************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic stop_test;
      $display("TB: failures=%0d tests_run=%0d", failures, tests_run);
      if (failures == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : stop_test

   // ******************************
   // Scenarios
   // ******************************
   task automatic t_write;
      for (int m = 0; m < 4; m++) begin
         u_ctrl.cmd(1'b0, WR, 2'h2, 12'(90 + m), 2'(m), 16'(16'h1234 + m));
         #1 chk(32'(core_req.wr), 32'(m != 3));
         if (m != 3) begin
            chk(32'(core_req.byte_en), 32'(~m & 3));
            chk(32'(core_req.wdata), 32'(16'h1234 + m));
            chk(32'({core_req.bank, core_req.row, core_req.col}),
                32'({2'h2, 12'habc, 8'(90 + m)}));
         end
      end
   endtask : t_write

   task automatic t_read;
      for (int m = 0; m < 4; m++) begin
         logic [DATA_W-1:0] eoe;
         eoe = {{8{~m[1]}}, {8{~m[0]}}};
         u_ctrl.cmd(1'b0, RD, 2'h2, 12'h033, 2'(m), 16'h0000);
         core_rdata <= 16'(16'hbe00 + m);
         #1 chk(32'(core_req.rd), 32'h1);
         chk(32'({core_req.col, core_req.row}), 32'({8'h33, 12'habc}));
         @(posedge sys_clk);
         @(posedge sys_clk);
         #1 chk(32'(data_bus_en), 32'(eoe));
         chk(32'(data_bus_drive & eoe), 32'(16'(16'hbe00 + m) & eoe));
      end
   endtask : t_read

   task automatic t_precharge;
      u_ctrl.cmd(1'b0, ACT, 2'h0, 12'h001, 2'h0, 16'h0000);
      u_ctrl.cmd(1'b0, ACT, 2'h1, 12'h002, 2'h0, 16'h0000);
      u_ctrl.cmd(1'b0, PRE, 2'h2, 12'h000, 2'h0, 16'h0000);
      #1 chk(32'(bank_open), 32'h3);
      u_ctrl.cmd(1'b0, PRE, 2'h0, 12'h400, 2'h0, 16'h0000);
      #1 chk(32'(bank_open), 32'h0);
      u_ctrl.cmd(1'b0, ACT, 2'h2, 12'h0ab, 2'h0, 16'h0000);
      u_ctrl.cmd(1'b0, WR, 2'h2, 12'h45a, 2'h0, 16'h5555);
      @(posedge sys_clk);
      #1 chk(32'(bank_open), 32'h0);
   endtask : t_precharge

   task automatic t_mode_cs;
      u_ctrl.cmd(1'b0, LMR, 2'h0, 12'h232, 2'h0, 16'h0000);
      #1 chk(32'(mode_reg), 32'h232);
      u_ctrl.cmd(1'b1, ACT, 2'h3, 12'h0ff, 2'h0, 16'h0000);
      #1 chk(32'(bank_open), 32'h0);
      u_ctrl.cmd(1'b1, LMR, 2'h0, 12'h015, 2'h0, 16'h0000);
      #1 chk(32'(mode_reg), 32'h232);
   endtask : t_mode_cs

   task automatic t_clock_enable;
      @(posedge sys_clk);
      cke <= 1'b0;
      u_ctrl.cmd(1'b0, ACT, 2'h1, 12'h010, 2'h0, 16'h0000);
      #1 chk(32'(bank_open), 32'h0);
      chk(32'(power_state == PWR_RUN), 32'h0);
      @(posedge sys_clk);
      cke <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1 chk(32'(power_state), 32'(PWR_RUN));
      u_ctrl.cmd(1'b0, ACT, 2'h1, 12'h010, 2'h0, 16'h0000);
      #1 chk(32'(bank_open), 32'h2);
   endtask : t_clock_enable

   // Refresh with enable dropping enters self refresh; a read in flight suspends
   task automatic t_power;
      u_ctrl.cmd(1'b0, PRE, 2'h0, 12'h400, 2'h0, 16'h0000);
      fork
         u_ctrl.cmd(1'b0, REF, 2'h0, 12'h000, 2'h0, 16'h0000);
         begin
            @(posedge sys_clk);
            cke <= 1'b0;
         end
      join
      #1 chk(32'(power_state), 32'(PWR_SELF));
      @(posedge sys_clk);
      cke <= 1'b1;
      repeat (2) @(posedge sys_clk);
      u_ctrl.cmd(1'b0, RD, 2'h0, 12'h000, 2'h3, 16'h0000);
      cke <= 1'b0;
      @(posedge sys_clk);
      #1 chk(32'(power_state), 32'(PWR_SUSPEND));
      @(posedge sys_clk);
      cke <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1 chk(32'(power_state), 32'(PWR_RUN));
   endtask : t_power

   initial begin
      repeat (4) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      u_ctrl.cmd(1'b0, ACT, 2'h2, 12'habc, 2'h0, 16'h0000);
      #1 chk(32'(bank_open), 32'h4);
      t_write();
      t_read();
      t_precharge();
      t_mode_cs();
      t_clock_enable();
      t_power();
      stop_test();
   end

   // Cut a hang short
   initial begin
      #100000;
      failures++;
      stop_test();
   end
endmodule : sdram_pin_command_interface_bench
